// >>> rtl/sentence_link_pkg.sv
// package of shared constants and types for the sentence link pacing
package sentence_link_pkg;

    // ********************************
    // timing
    // ********************************
    localparam int unsigned clock_hz = 100_000_000;
    localparam int unsigned period_ms = 1000;
    localparam int unsigned spacing_ms = 50;
    localparam int unsigned direct_meas_ms = 150;
    localparam int unsigned hours_min = 30;
    localparam int unsigned cycles_per_ms = clock_hz / 1000;
    localparam int unsigned tick_count = cycles_per_ms;

    // ********************************
    // sentence kinds
    // ********************************
    typedef enum logic [3:0]
    {
        kind_none = 4'h0,
        kind_operational_control = 4'h1,
        kind_blanking_zone = 4'h2,
        kind_operating_hours = 4'h3,
        kind_trim_control = 4'h4,
        kind_setup = 4'h5,
        kind_motor_speed_setup = 4'h6,
        kind_state_report = 4'h7,
        kind_measurement = 4'h8,
        kind_link_health = 4'h9,
        kind_voltage_report = 4'ha,
        kind_reject_report = 4'hb,
        kind_trim_report = 4'hc,
        kind_blanking_report = 4'hd
    } kind_t;

    // ********************************
    // fault classes and error codes
    // ********************************
    typedef enum logic [2:0]
    {
        fault_none = 3'h0,
        fault_checksum = 3'h1,
        fault_format = 3'h2,
        fault_missing = 3'h3,
        fault_range = 3'h4
    } fault_t;

    localparam logic [7:0] code_checksum = 8'h00;
    localparam logic [7:0] code_format = 8'h01;
    localparam logic [7:0] code_missing = 8'h02;
    localparam logic [7:0] code_range = 8'h03;

    // request field of the operating-hours command
    localparam logic [1:0] hours_request = 2'h1;

endpackage

// >>> rtl/sentence_link_if.sv
// interface joining the controller end and the transceiver end
`timescale 1ns/100ps
interface sentence_link_if;
    import sentence_link_pkg::*;

    // controller to transceiver
    logic cmd_valid;
    kind_t cmd_kind;
    fault_t cmd_fault;
    logic [1:0] cmd_arg;
    // transceiver to controller
    logic rep_valid;
    kind_t rep_kind;
    logic [7:0] rep_code;
    kind_t rep_about;

    modport controller
    (
        output cmd_valid,
        output cmd_kind,
        output cmd_fault,
        output cmd_arg,
        input rep_valid,
        input rep_kind,
        input rep_code,
        input rep_about
    );

    modport transceiver
    (
        input cmd_valid,
        input cmd_kind,
        input cmd_fault,
        input cmd_arg,
        output rep_valid,
        output rep_kind,
        output rep_code,
        output rep_about
    );
endinterface

// >>> rtl/ms_ticker.sv
// millisecond enable pulse divider
`timescale 1ns/100ps
module ms_ticker
    import sentence_link_pkg::*;
#(
    parameter int unsigned cycles = tick_count
)
(
    input wire logic clock,
    input wire logic nrst,
    output logic tick
);
    if (cycles < 2)
    begin : g_bad_cycles
        $error("ms_ticker needs at least two cycles per tick");
    end

    logic [31:0] count_q;
    logic [31:0] count_d;

    always_comb
    begin
        count_d = count_q + 32'h1;
        if (count_q == 32'(cycles - 1))
            count_d = 32'h0;
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            count_q <= 32'h0;
        else
            count_q <= count_d;
    end

    assign tick = (count_q == 32'(cycles - 1));
endmodule

// >>> rtl/transceiver_end.sv
// transceiver end: periodic reports, on-request replies, reject codes
`timescale 1ns/100ps
// Behaviour
// - controller sends control once per second
// - controller sends blanking only on change; controller_end sends it on every accepted request
// - controller sends hours command only when needed
// - controller sends trim control only when needed
// - setup sentences only at installation
// - controller spaces sentence starts 50 ms
// - state, health, voltage reports each second
// - measurement 1 s via interface, else 150 ms
// - hours report on request and every 30 minutes
// - checksum code 00, format code 01
// - hours: missing type 02, range 03
// - trim: unknown pot 02, range 03
module transceiver_end
    import sentence_link_pkg::*;
#(
    parameter int unsigned ms_cycles = tick_count,
    parameter int unsigned hours_ms = hours_min * 60 * 1000
)
(
    input wire logic clock,
    input wire logic nrst,
    sentence_link_if.transceiver link,
    input wire logic via_interface,
    output logic cmd_seen,
    output kind_t cmd_seen_kind,
    output logic [1:0] cmd_seen_arg
);
    if (hours_ms < 1)
    begin : g_bad_hours
        $error("transceiver_end needs a positive hours period");
    end

    // ********************************
    // timers
    // ********************************
    logic tick;
    ms_ticker #(.cycles(ms_cycles)) u_tick
    (
        .clock(clock),
        .nrst(nrst),
        .tick(tick)
    );

    logic [9:0] sec_q, sec_d;
    logic [7:0] meas_q, meas_d;
    logic [31:0] hours_q, hours_d;
    logic [7:0] pend_q, pend_d;
    kind_t about_q, about_d;
    logic [7:0] code_q, code_d;
    logic valid_q, valid_d;
    kind_t kind_q, kind_d;
    logic seen_q, seen_d;
    kind_t seen_kind_q, seen_kind_d;
    logic [1:0] seen_arg_q, seen_arg_d;
    logic meas_due;

    // pending bits: 0 state, 1 health, 2 voltage, 3 measurement,
    // 4 hours, 5 reject, 6 trim report, 7 blanking report

    function automatic logic [7:0] error_code(input fault_t f);
        case (f)
            fault_checksum: error_code = code_checksum;
            fault_format: error_code = code_format;
            fault_missing: error_code = code_missing;
            fault_range: error_code = code_range;
            default: error_code = code_format;
        endcase
    endfunction

    always_comb
    begin
        sec_d = sec_q;
        meas_d = meas_q;
        hours_d = hours_q;
        pend_d = pend_q;
        about_d = about_q;
        code_d = code_q;
        valid_d = 1'b0;
        kind_d = kind_q;
        seen_d = 1'b0;
        seen_kind_d = seen_kind_q;
        seen_arg_d = seen_arg_q;
        meas_due = 1'b0;
        if (tick)
        begin
            sec_d = sec_q + 10'h1;
            if (sec_q == 10'(period_ms - 1))
            begin
                sec_d = 10'h0;
                pend_d[2:0] = 3'b111;
            end
            meas_d = meas_q + 8'h1;
            if (via_interface)
                meas_due = (sec_q == 10'(period_ms - 1));
            else if (meas_q == 8'(direct_meas_ms - 1))
                meas_due = 1'b1;
            if (meas_due || meas_q == 8'(direct_meas_ms - 1))
                meas_d = 8'h0;
            if (meas_due)
                pend_d[3] = 1'b1;
            hours_d = hours_q + 32'h1;
            if (hours_q == 32'(hours_ms - 1))
            begin
                hours_d = 32'h0;
                pend_d[4] = 1'b1;
            end
        end
        if (link.cmd_valid)
        begin
            if (link.cmd_fault != fault_none)
            begin
                pend_d[5] = 1'b1;
                about_d = link.cmd_kind;
                code_d = error_code(link.cmd_fault);
            end
            else
            begin
                seen_d = 1'b1;
                seen_kind_d = link.cmd_kind;
                seen_arg_d = link.cmd_arg;
                case (link.cmd_kind)
                    kind_operating_hours:
                        if (link.cmd_arg == hours_request)
                            pend_d[4] = 1'b1;
                    kind_trim_control: pend_d[6] = 1'b1;
                    kind_blanking_zone: pend_d[7] = 1'b1;
                    default: ;
                endcase
            end
        end
        // one report per cycle, lowest pending bit first
        if (pend_d != 8'h0)
        begin
            valid_d = 1'b1;
            case (1'b1)
                pend_d[0]:
                begin
                    kind_d = kind_state_report;
                    pend_d[0] = 1'b0;
                end
                pend_d[1]:
                begin
                    kind_d = kind_link_health;
                    pend_d[1] = 1'b0;
                end
                pend_d[2]:
                begin
                    kind_d = kind_voltage_report;
                    pend_d[2] = 1'b0;
                end
                pend_d[3]:
                begin
                    kind_d = kind_measurement;
                    pend_d[3] = 1'b0;
                end
                pend_d[4]:
                begin
                    kind_d = kind_operating_hours;
                    pend_d[4] = 1'b0;
                end
                pend_d[5]:
                begin
                    kind_d = kind_reject_report;
                    pend_d[5] = 1'b0;
                end
                pend_d[6]:
                begin
                    kind_d = kind_trim_report;
                    pend_d[6] = 1'b0;
                end
                default:
                begin
                    kind_d = kind_blanking_report;
                    pend_d[7] = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            sec_q <= 10'h0;
            meas_q <= 8'h0;
            hours_q <= 32'h0;
            pend_q <= 8'h0;
            about_q <= kind_none;
            code_q <= 8'h0;
            valid_q <= 1'b0;
            kind_q <= kind_none;
            seen_q <= 1'b0;
            seen_kind_q <= kind_none;
            seen_arg_q <= 2'h0;
        end
        else
        begin
            sec_q <= sec_d;
            meas_q <= meas_d;
            hours_q <= hours_d;
            pend_q <= pend_d;
            about_q <= about_d;
            code_q <= code_d;
            valid_q <= valid_d;
            kind_q <= kind_d;
            seen_q <= seen_d;
            seen_kind_q <= seen_kind_d;
            seen_arg_q <= seen_arg_d;
        end
    end

    assign link.rep_valid = valid_q;
    assign link.rep_kind = kind_q;
    assign link.rep_code = code_q;
    assign link.rep_about = about_q;
    assign cmd_seen = seen_q;
    assign cmd_seen_kind = seen_kind_q;
    assign cmd_seen_arg = seen_arg_q;
endmodule

// >>> rtl/controller_end.sv
// controller end: sends commands paced to the link rules
`timescale 1ns/100ps
module controller_end
    import sentence_link_pkg::*;
#(
    parameter int unsigned ms_cycles = tick_count
)
(
    input wire logic clock,
    input wire logic nrst,
    sentence_link_if.controller link,
    input wire logic req_valid,
    output logic req_ready,
    input kind_t req_kind,
    input fault_t req_fault,
    input logic [1:0] req_arg,
    input wire logic installing,
    output logic rep_seen,
    output kind_t rep_seen_kind,
    output logic [7:0] rep_seen_code,
    output kind_t rep_seen_about
);
    logic tick;
    ms_ticker #(.cycles(ms_cycles)) u_tick
    (
        .clock(clock),
        .nrst(nrst),
        .tick(tick)
    );

    logic [9:0] sec_q, sec_d;
    logic [5:0] gap_q, gap_d;
    logic due_q, due_d;
    logic valid_q, valid_d;
    kind_t kind_q, kind_d;
    fault_t fault_q, fault_d;
    logic [1:0] arg_q, arg_d;
    logic seen_q, seen_d;
    kind_t sk_q, sk_d;
    logic [7:0] sc_q, sc_d;
    kind_t sa_q, sa_d;
    logic allowed;

    assign allowed = installing ||
        (req_kind != kind_setup && req_kind != kind_motor_speed_setup);
    assign req_ready = (gap_q == 6'h0) && !due_q && allowed;

    always_comb
    begin
        sec_d = sec_q;
        gap_d = gap_q;
        due_d = due_q;
        valid_d = 1'b0;
        kind_d = kind_q;
        fault_d = fault_q;
        arg_d = arg_q;
        seen_d = link.rep_valid;
        sk_d = link.rep_valid ? link.rep_kind : sk_q;
        sc_d = link.rep_valid ? link.rep_code : sc_q;
        sa_d = link.rep_valid ? link.rep_about : sa_q;
        if (tick)
        begin
            if (gap_q != 6'h0)
                gap_d = gap_q - 6'h1;
            sec_d = sec_q + 10'h1;
            if (sec_q == 10'(period_ms - 1))
            begin
                sec_d = 10'h0;
                due_d = 1'b1;
            end
        end
        if (gap_q == 6'h0 && due_q)
        begin
            valid_d = 1'b1;
            kind_d = kind_operational_control;
            fault_d = fault_none;
            arg_d = 2'h0;
            due_d = 1'b0;
            // one spare tick: the first tick may follow at once
            gap_d = 6'(spacing_ms + 1);
        end
        else if (req_valid && req_ready)
        begin
            valid_d = 1'b1;
            kind_d = req_kind;
            fault_d = req_fault;
            arg_d = req_arg;
            gap_d = 6'(spacing_ms + 1);
        end
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            sec_q <= 10'h0;
            gap_q <= 6'h0;
            due_q <= 1'b0;
            valid_q <= 1'b0;
            kind_q <= kind_none;
            fault_q <= fault_none;
            arg_q <= 2'h0;
            seen_q <= 1'b0;
            sk_q <= kind_none;
            sc_q <= 8'h0;
            sa_q <= kind_none;
        end
        else
        begin
            sec_q <= sec_d;
            gap_q <= gap_d;
            due_q <= due_d;
            valid_q <= valid_d;
            kind_q <= kind_d;
            fault_q <= fault_d;
            arg_q <= arg_d;
            seen_q <= seen_d;
            sk_q <= sk_d;
            sc_q <= sc_d;
            sa_q <= sa_d;
        end
    end

    assign link.cmd_valid = valid_q;
    assign link.cmd_kind = kind_q;
    assign link.cmd_fault = fault_q;
    assign link.cmd_arg = arg_q;
    assign rep_seen = seen_q;
    assign rep_seen_kind = sk_q;
    assign rep_seen_code = sc_q;
    assign rep_seen_about = sa_q;
endmodule

// >>> verification/sentence_link_properties.sv
// concurrent checks on the link between the two ends
`timescale 1ns/100ps
module sentence_link_properties
    import sentence_link_pkg::*;
#(
    parameter int unsigned ms_cycles = tick_count
)
(
    input wire logic clock,
    input wire logic nrst,
    input logic cmd_valid,
    input kind_t cmd_kind,
    input fault_t cmd_fault,
    input logic [1:0] cmd_arg,
    input logic rep_valid,
    input kind_t rep_kind,
    input logic [7:0] rep_code,
    input kind_t rep_about
);
    // ********************
    // helper counters
    // ********************
    localparam int gap_min = int'(spacing_ms * ms_cycles) - 1;
    localparam int per = int'(period_ms * ms_cycles);
    int gap_q, gap_d, age_q, age_d, st_q, st_d;
    logic rej, bad, st;
    assign rej = rep_valid && rep_kind == kind_reject_report;
    assign bad = cmd_valid && cmd_fault != fault_none;
    assign st = rep_valid && rep_kind == kind_state_report;

    // saturate so a quiet link cannot wrap
    always_comb
    begin
        gap_d = cmd_valid ? 0 : gap_q + ((gap_q < per) ? 1 : 0);
        age_d = bad ? 0 : age_q + ((age_q < 99) ? 1 : 0);
        st_d = st ? 0 : st_q + ((st_q < 2 * per) ? 1 : 0);
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            gap_q <= per;
            age_q <= 99;
            st_q <= 0;
        end
        else
        begin
            gap_q <= gap_d;
            age_q <= age_d;
            st_q <= st_d;
        end
    end

    // ********************
    // properties
    // ********************
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    a_start_spacing: assert property (
        cmd_valid |-> gap_q >= gap_min)
        else $error("sentence starts too close");
    a_state_period: assert property (
        st |-> st_q >= per - 9)
        else $error("state report too early");
    a_state_due: assert property (
        st_q <= per + 8)
        else $error("state report overdue");
    // reply leaves one cycle after the command at the earliest
    a_checksum_code: assert property (
        cmd_valid && cmd_fault == fault_checksum
        |-> ##[1:8] (rej && rep_code == code_checksum))
        else $error("checksum reject code wrong");
    a_format_code: assert property (
        cmd_valid && cmd_fault == fault_format
        |-> ##[1:8] (rej && rep_code == code_format))
        else $error("format reject code wrong");
    // command kind holds until the next start, far beyond eight cycles
    a_missing_code: assert property (
        cmd_valid && cmd_fault == fault_missing
        |-> ##[1:8] (rej && rep_code == code_missing
        && rep_about == $past(cmd_kind)))
        else $error("missing reject code wrong");
    a_range_code: assert property (
        cmd_valid && cmd_fault == fault_range
        |-> ##[1:8] (rej && rep_code == code_range))
        else $error("range reject code wrong");
    a_reject_cause: assert property (
        rej |-> age_q <= 8)
        else $error("reject without faulty command");
    a_hours_answer: assert property (
        cmd_valid && cmd_fault == fault_none
        && cmd_kind == kind_operating_hours && cmd_arg == hours_request
        |-> ##[1:8] (rep_valid && rep_kind == kind_operating_hours))
        else $error("hours request unanswered");
    a_trim_answer: assert property (
        cmd_valid && cmd_fault == fault_none
        && cmd_kind == kind_trim_control
        |-> ##[1:8] (rep_valid && rep_kind == kind_trim_report))
        else $error("trim request unanswered");
endmodule

// >>> verification/testbench.sv
// bench joining the controller end and the transceiver end
`timescale 1ns/100ps
`define check(got, exp) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) \
        begin \
            errors++; \
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp); \
        end \
    end
module testbench;
    import sentence_link_pkg::*;
    localparam int unsigned ms = 10;
    localparam int slow = 1000 * ms;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic req_valid = 1'b0;
    logic installing = 1'b0;
    logic via = 1'b0;
    kind_t req_kind = kind_none;
    fault_t req_fault = fault_none;
    logic [1:0] req_arg = 2'h0;
    logic req_ready, rep_seen, cmd_seen;
    kind_t rep_seen_kind, rep_seen_about, cmd_seen_kind;
    logic [7:0] rep_seen_code;
    logic [1:0] cmd_seen_arg;
    int errors = 0;
    int checks_done = 0;
    int cycles = 0;
    int cnt[16], first[16], last[16];

    sentence_link_if link ();
    controller_end #(.ms_cycles(ms)) controller_end_i (
        .clock(clock), .nrst(nrst), .link(link.controller),
        .req_valid(req_valid), .req_ready(req_ready), .req_kind(req_kind),
        .req_fault(req_fault), .req_arg(req_arg), .installing(installing),
        .rep_seen(rep_seen), .rep_seen_kind(rep_seen_kind),
        .rep_seen_code(rep_seen_code), .rep_seen_about(rep_seen_about));
    transceiver_end #(.ms_cycles(ms), .hours_ms(50)) transceiver_end_i (
        .clock(clock), .nrst(nrst), .link(link.transceiver),
        .via_interface(via), .cmd_seen(cmd_seen),
        .cmd_seen_kind(cmd_seen_kind), .cmd_seen_arg(cmd_seen_arg));
    sentence_link_properties #(.ms_cycles(ms)) sentence_link_properties_i (
        .clock(clock), .nrst(nrst), .cmd_valid(link.cmd_valid),
        .cmd_kind(link.cmd_kind), .cmd_fault(link.cmd_fault),
        .cmd_arg(link.cmd_arg), .rep_valid(link.rep_valid),
        .rep_kind(link.rep_kind), .rep_code(link.rep_code),
        .rep_about(link.rep_about));

    initial
    begin
        forever #5 clock = ~clock;
    end

    // ********************
    // helpers
    // ********************
    task automatic summarize;
        $display("errors=%0d checks_done=%0d", errors, checks_done);
        if (errors == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // hang guard: whole run needs about 55000 cycles
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 80000)
        begin
            errors++;
            summarize();
        end
    end

    function automatic logic near(input int x, input int p);
        return x >= p - 8 && x <= p + 8;
    endfunction

    function automatic int per_of(input kind_t k);
        return cnt[k] > 1 ? (last[k] - first[k]) / (cnt[k] - 1) : 0;
    endfunction

    // request held until taken at an edge with ready high
    task automatic send(input kind_t k, input fault_t f, input logic [1:0] a);
        int n;
        @(posedge clock);
        req_kind <= k;
        req_fault <= f;
        req_arg <= a;
        req_valid <= 1'b1;
        n = 0;
        do
        begin
            @(negedge clock);
            n++;
        end
        while (req_ready !== 1'b1 && n < 20000);
        @(posedge clock);
        req_valid <= 1'b0;
    endtask

    task automatic wait_rep(input kind_t k, output int n);
        n = 0;
        do
        begin
            @(negedge clock);
            n++;
        end
        while (!(link.rep_valid === 1'b1 && link.rep_kind === k) && n < 20);
    endtask

    // ********************
    // scenarios
    // ********************
    task automatic test_reject_codes;
        kind_t k[8] = '{kind_operational_control, kind_blanking_zone,
            kind_operating_hours, kind_operating_hours, kind_trim_control,
            kind_trim_control, kind_trim_control, kind_blanking_zone};
        fault_t f[8] = '{fault_missing, fault_missing, fault_missing,
            fault_range, fault_missing, fault_range, fault_checksum,
            fault_format};
        logic [7:0] c[8] = '{8'h02, 8'h02, 8'h02, 8'h03, 8'h02, 8'h03,
            8'h00, 8'h01};
        int n;
        for (int i = 0; i < 8; i++)
        begin
            send(k[i], f[i], 2'h0);
            n = 0;
            do
            begin
                @(negedge clock);
                n++;
            end
            while ((rep_seen !== 1'b1 || rep_seen_kind !== kind_reject_report)
                && n < 30);
            `check(n < 30, 1'b1)
            `check(rep_seen_code, c[i])
            `check(rep_seen_about, k[i])
        end
    endtask

    task automatic test_replies;
        kind_t k[3] = '{kind_operating_hours, kind_trim_control,
            kind_blanking_zone};
        kind_t r[3] = '{kind_operating_hours, kind_trim_report,
            kind_blanking_report};
        int n;
        for (int i = 0; i < 3; i++)
        begin
            send(k[i], fault_none, hours_request);
            wait_rep(r[i], n);
            `check(n < 20, 1'b1)
            // a periodic hours report may come before the command lands
            repeat (2) @(negedge clock);
            `check(cmd_seen_kind, k[i])
            `check(cmd_seen_arg, hours_request)
        end
    endtask

    task automatic test_spacing;
        int n;
        send(kind_operational_control, fault_none, 2'h0);
        n = 0;
        do
        begin
            @(negedge clock);
            n++;
        end
        while (req_ready !== 1'b1 && n < 2000);
        `check(n >= spacing_ms * ms, 1'b1)
    endtask

    task automatic test_setup;
        kind_t k[2] = '{kind_setup, kind_motor_speed_setup};
        int n;
        for (int i = 0; i < 2; i++)
        begin
            @(posedge clock);
            req_kind <= k[i];
            repeat (60 * ms) @(negedge clock);
            `check(req_ready, 1'b0)
            @(posedge clock);
            installing <= 1'b1;
            send(k[i], fault_none, 2'h0);
            n = 0;
            do
            begin
                @(negedge clock);
                n++;
            end
            while (cmd_seen !== 1'b1 && n < 20);
            `check(cmd_seen_kind, k[i])
            @(posedge clock);
            installing <= 1'b0;
        end
    endtask

    // rate of each report kind averaged over a long quiet stretch
    task automatic window(input logic v, input int p_meas);
        int k;
        int j;
        int others;
        @(posedge clock);
        via <= v;
        others = 0;
        for (int i = 0; i < 16; i++)
            cnt[i] = 0;
        for (int t = 0; t < 23000; t++)
        begin
            @(negedge clock);
            k = int'(link.rep_kind);
            j = int'(link.cmd_kind);
            if (t >= 2000 && link.rep_valid === 1'b1)
            begin
                if (cnt[k] == 0)
                    first[k] = t;
                last[k] = t;
                cnt[k]++;
            end
            // control kind never names a report, so its slot is free
            if (t >= 2000 && link.cmd_valid === 1'b1)
            begin
                if (j != int'(kind_operational_control))
                    others++;
                else
                begin
                    if (cnt[j] == 0)
                        first[j] = t;
                    last[j] = t;
                    cnt[j]++;
                end
            end
        end
        `check(near(per_of(kind_measurement), p_meas), 1'b1)
        `check(near(per_of(kind_operational_control), slow), 1'b1)
        `check(others, 0)
        if (!v)
        begin
            `check(near(per_of(kind_state_report), slow), 1'b1)
            `check(near(per_of(kind_link_health), slow), 1'b1)
            `check(near(per_of(kind_voltage_report), slow), 1'b1)
            `check(near(per_of(kind_operating_hours), 50 * ms), 1'b1)
            k = cnt[kind_reject_report] + cnt[kind_trim_report];
            k += cnt[kind_blanking_report];
            `check(k, 0)
        end
    endtask

    initial
    begin
        repeat (12) @(posedge clock);
        nrst <= 1'b1;
        test_reject_codes();
        test_replies();
        test_spacing();
        test_setup();
        window(1'b0, 150 * ms);
        window(1'b1, slow);
        summarize();
    end
endmodule
